/* File: verilog/cssm_top.sv */
// Operation
// - first power-up loads the factory set
// - later boots reload the last activated set; a power-up here boots the factory set, as the valid flags clear
// - no activated set means factory set
// - activation loads set and records boot link
// - cache on holds cached writes pending
// - cache off commits all after frame end
// - only imaging parameters are cached
// - other parameters apply at once
// - cache mode field switches caching
// - failing changes discarded, old value kept
// - range, value or dependency conflicts fail
// - parameter error bit in status field
// - reset field reboots like a power cycle but keeps user sets and boot link
// - periodic self checks, codes, LED blink
// - user sets move by bulk transfer
`timescale 1ns/1ps
`default_nettype none
module cssm_top
   import cssm_pkg::*;
#(
   parameter int SELFTEST_CYCLES = SELFTEST_CYC,
   parameter int BLINK_CYCLES = BLINK_CYC
) (
   input wire logic i_sys_clk,
   input wire logic i_rst,
   input wire logic i_psel,
   input wire logic i_penable,
   input wire logic i_pwrite,
   input wire logic [11:0] i_paddr,
   input wire logic [31:0] i_pwdata,
   output logic [31:0] o_prdata,
   output logic o_pready,
   output logic o_pslverr,
   input wire logic i_frame_done,
   input wire logic [3:0] i_fault,
   input wire logic [2:0] i_nv_link,
   input wire logic i_nv_first_boot,
   output logic [NPAR*PW-1:0] o_work_set,
   output logic [2:0] o_nv_link,
   output logic o_nv_link_we,
   output logic o_soft_rst,
   output logic o_status_led
);
   localparam int STW = $clog2(SELFTEST_CYCLES + 1);
   localparam int BLW = $clog2(BLINK_CYCLES + 1);

   // apb slave
   logic pready_r, pready_nxt;
   logic pslverr_r, pslverr_nxt;
   logic [31:0] prdata_r, prdata_nxt;
   logic [31:0] rd_mux;
   logic acc;
   logic fire;
   logic wr;
   logic aligned;
   logic hit_cache;
   logic hit_reset;
   logic hit_status;
   logic hit_set;
   logic hit_param;
   logic hit_user;
   logic addr_hit;

   // state
   cssm_state_t st_r, st_nxt;
   logic [3:0] boot_cnt_r, boot_cnt_nxt;
   logic running;
   logic load_go;
   logic from_pins_r;
   logic [2:0] link_r, link_nxt;
   logic [3:0] user_valid_r, user_valid_nxt;
   logic cache_on_r, cache_on_nxt;
   logic pend_r, pend_nxt;
   logic perr_r, perr_nxt;
   logic nv_we_r;
   logic soft_rst_r;

   logic [NPAR-1:0][PW-1:0] work_r, work_nxt;
   logic [NPAR-1:0][PW-1:0] shadow_r, shadow_nxt;
   logic [NPAR-1:0][PW-1:0] src_set;
   logic [PW-1:0] user_r [NUSER][NPAR];

   // pin synchronisers and self check
   logic [7:0] pin_raw;
   logic [7:0] pin_s1_r;
   logic [7:0] pin_s2_r;
   logic [7:0] pin_s3_r;
   logic [7:0] pin_f_r;
   logic [7:0] pin_f_nxt;
   logic [3:0] fault_f;
   logic [2:0] nv_link_f;
   logic nv_first_f;
   logic [STW-1:0] st_cnt_r, st_cnt_nxt;
   logic st_tick;
   logic [3:0] err_code_r;
   logic [BLW-1:0] blink_cnt_r, blink_cnt_nxt;
   logic blink_r;
   logic led_r;
   logic led_nxt;

   // access decode
   assign acc = i_psel & i_penable;
   assign fire = acc & pready_r;
   assign aligned = i_paddr[1:0] == 2'b00;
   assign hit_cache = i_paddr == REG_CACHE_CTRL;
   assign hit_reset = i_paddr == REG_RESET_CTRL;
   assign hit_status = i_paddr == REG_STATUS;
   assign hit_set = i_paddr == REG_SET_CTRL;
   assign hit_param = aligned & (i_paddr[11:5] == PARAM_PAGE);
   assign hit_user = aligned & (i_paddr[11:7] == USER_PAGE);
   assign addr_hit = hit_cache | hit_reset | hit_status | hit_set | hit_param | hit_user;
   assign wr = fire & i_pwrite & addr_hit;
   assign running = st_r == ST_RUN;

   // parameter write path
   logic [2:0] pw_idx;
   logic [PW-1:0] pw_val;
   logic chk_ok;
   logic par_wr;
   logic par_ok;
   logic par_bad;
   assign pw_idx = i_paddr[4:2];
   assign pw_val = i_pwdata[PW-1:0];
   assign par_wr = wr & hit_param & running;

   cssm_param_check u_check (
      .i_idx(pw_idx),
      .i_val(pw_val),
      .i_view(shadow_r),
      .o_ok(chk_ok)
   );

   assign par_ok = par_wr & chk_ok;
   assign par_bad = par_wr & ~chk_ok;

   // set save / activate
   logic set_wr;
   logic [2:0] slot;
   logic [1:0] sl_idx;
   logic slot_user;
   logic save_go;
   logic act_go;
   logic ld;
   logic [2:0] boot_link;
   logic [1:0] boot_idx;
   logic [2:0] boot_slot;
   logic [2:0] load_slot;
   logic [1:0] load_idx;
   logic up_go;
   logic [1:0] up_slot;
   logic rst_wr;
   logic commit_go;
   logic hold;
   assign set_wr = wr & hit_set & running;
   assign slot = i_pwdata[SET_SLOT_LSB +: 3];
   assign sl_idx = 2'(slot - 3'h1);
   assign slot_user = (slot != SLOT_FACTORY) && (slot <= MAX_USER_SLOT);
   assign save_go = set_wr & i_pwdata[SET_SAVE_BIT] & slot_user;
   assign act_go = set_wr & i_pwdata[SET_ACT_BIT] & ~i_pwdata[SET_SAVE_BIT]
                 & ((slot == SLOT_FACTORY) | (slot_user & user_valid_r[sl_idx]));
   assign up_go = wr & hit_user & running;
   assign up_slot = i_paddr[6:5];
   assign rst_wr = wr & hit_reset & i_pwdata[RESET_BIT];

   // boot source: factory on first boot or without a usable link
   assign boot_link = from_pins_r ? nv_link_f : link_r;
   assign boot_idx = 2'(boot_link - 3'h1);
   assign boot_slot = ((from_pins_r & nv_first_f) | (boot_link == SLOT_FACTORY)
                      | (boot_link > MAX_USER_SLOT) | ~user_valid_r[boot_idx])
                      ? SLOT_FACTORY : boot_link;
   assign load_go = (st_r == ST_BOOT) && (boot_cnt_r == BOOT_WAIT_CYC - 4'h1);
   assign ld = load_go | act_go;
   assign load_slot = load_go ? boot_slot : slot;
   assign load_idx = 2'(load_slot - 3'h1);

   // cache control
   assign hold = cache_on_r | pend_r;
   assign commit_go = pend_r & i_frame_done & ~cache_on_r & running;

   genvar gi;
   generate
      for (gi = 0; gi < NPAR; gi++) begin : g_par
         logic wsel;
         assign wsel = par_ok & (pw_idx == 3'(gi));
         assign src_set[gi] = (load_slot == SLOT_FACTORY) ? PAR_FACTORY[gi] : user_r[load_idx][gi];
         assign shadow_nxt[gi] = ld ? src_set[gi] : wsel ? pw_val : shadow_r[gi];
         assign work_nxt[gi] = ld ? src_set[gi]
                             : (commit_go & CACHED_MASK[gi]) ? shadow_nxt[gi]
                             : (wsel & ~(CACHED_MASK[gi] & hold)) ? pw_val
                             : work_r[gi];
      end
   endgenerate

   assign cache_on_nxt = rst_wr ? 1'b0 : (wr & hit_cache) ? i_pwdata[CACHE_MODE_BIT] : cache_on_r;
   // a commit still goes ahead when caching is re-enabled in the same cycle
   assign pend_nxt = rst_wr ? 1'b0
                   : (wr & hit_cache & cache_on_r & ~i_pwdata[CACHE_MODE_BIT]) | (pend_r & ~commit_go);
   assign perr_nxt = rst_wr ? 1'b0 : par_bad | (perr_r & ~(par_ok | ld));
   assign link_nxt = ld ? load_slot : link_r;
   assign user_valid_nxt = user_valid_r | ({3'h0, save_go} << sl_idx) | ({3'h0, up_go} << up_slot);
   assign st_nxt = rst_wr ? ST_BOOT : load_go ? ST_RUN : st_r;
   assign boot_cnt_nxt = rst_wr ? 4'h0 : (st_r == ST_BOOT) ? boot_cnt_r + 4'h1 : boot_cnt_r;

   // read mux
   logic [31:0] stat_word;
   logic [PW-1:0] user_rd;
   assign stat_word = {16'h0000, user_valid_r, 1'b0, link_r, err_code_r, ~running, pend_r, cache_on_r, perr_r};
   assign user_rd = user_valid_r[up_slot] ? user_r[up_slot][pw_idx] : 16'h0000;
   assign rd_mux = hit_cache ? {31'h00000000, cache_on_r}
                 : hit_status ? stat_word
                 : hit_set ? {29'h00000000, link_r}
                 : hit_param ? {16'h0000, shadow_r[pw_idx]}
                 : hit_user ? {16'h0000, user_rd}
                 : 32'h00000000;
   assign pready_nxt = acc & ~pready_r;
   assign pslverr_nxt = acc & ~pready_r & ~addr_hit;
   assign prdata_nxt = (acc & ~pready_r) ? rd_mux : prdata_r;

   always_ff @(posedge i_sys_clk or posedge i_rst) begin
      if (i_rst) begin
         pready_r <= 1'b0;
         pslverr_r <= 1'b0;
         prdata_r <= 32'h00000000;
      end else begin
         pready_r <= pready_nxt;
         pslverr_r <= pslverr_nxt;
         prdata_r <= prdata_nxt;
      end
   end

   always_ff @(posedge i_sys_clk or posedge i_rst) begin
      if (i_rst) begin
         st_r <= ST_BOOT;
         boot_cnt_r <= 4'h0;
         from_pins_r <= 1'b1;
         link_r <= SLOT_FACTORY;
         user_valid_r <= 4'h0;
         cache_on_r <= 1'b0;
         pend_r <= 1'b0;
         perr_r <= 1'b0;
         nv_we_r <= 1'b0;
         soft_rst_r <= 1'b0;
      end else begin
         st_r <= st_nxt;
         boot_cnt_r <= boot_cnt_nxt;
         from_pins_r <= from_pins_r & ~load_go;
         link_r <= link_nxt;
         user_valid_r <= user_valid_nxt;
         cache_on_r <= cache_on_nxt;
         pend_r <= pend_nxt;
         perr_r <= perr_nxt;
         nv_we_r <= act_go;
         soft_rst_r <= rst_wr;
      end
   end

   always_ff @(posedge i_sys_clk or posedge i_rst) begin
      if (i_rst) begin
         for (int k = 0; k < NPAR; k++) begin
            work_r[k] <= PAR_FACTORY[k];
            shadow_r[k] <= PAR_FACTORY[k];
         end
      end else begin
         work_r <= work_nxt;
         shadow_r <= shadow_nxt;
      end
   end

   // user set store, survives soft reset
   always_ff @(posedge i_sys_clk) begin
      for (int k = 0; k < NPAR; k++) begin
         if (save_go) begin
            user_r[sl_idx][k] <= work_r[k];
         end else if (up_go && (pw_idx == 3'(k))) begin
            user_r[up_slot][k] <= pw_val;
         end
      end
   end

   // pins: three stages, accepted once stages two and three agree
   assign pin_raw = {i_nv_first_boot, i_nv_link, i_fault};
   assign pin_f_nxt = (pin_s2_r & pin_s3_r) | (pin_f_r & (pin_s2_r | pin_s3_r));
   assign fault_f = pin_f_r[3:0];
   assign nv_link_f = pin_f_r[6:4];
   assign nv_first_f = pin_f_r[7];

   always_ff @(posedge i_sys_clk or posedge i_rst) begin
      if (i_rst) begin
         pin_s1_r <= 8'h00;
         pin_s2_r <= 8'h00;
         pin_s3_r <= 8'h00;
         pin_f_r <= 8'h00;
      end else begin
         pin_s1_r <= pin_raw;
         pin_s2_r <= pin_s1_r;
         pin_s3_r <= pin_s2_r;
         pin_f_r <= pin_f_nxt;
      end
   end

   // periodic self check and status indicator
   assign st_tick = st_cnt_r == STW'(SELFTEST_CYCLES - 1);
   assign st_cnt_nxt = st_tick ? '0 : st_cnt_r + STW'(1);
   assign blink_cnt_nxt = (blink_cnt_r == BLW'(BLINK_CYCLES - 1)) ? '0 : blink_cnt_r + BLW'(1);
   assign led_nxt = ((err_code_r & BLINK_ERR_MASK) != 4'h0) ? blink_r : 1'b1;

   always_ff @(posedge i_sys_clk or posedge i_rst) begin
      if (i_rst) begin
         st_cnt_r <= '0;
         err_code_r <= 4'h0;
         blink_cnt_r <= '0;
         blink_r <= 1'b0;
         led_r <= 1'b0;
      end else begin
         st_cnt_r <= st_cnt_nxt;
         err_code_r <= st_tick ? fault_f : err_code_r;
         blink_cnt_r <= blink_cnt_nxt;
         blink_r <= blink_r ^ (blink_cnt_r == BLW'(BLINK_CYCLES - 1));
         led_r <= led_nxt;
      end
   end

   assign o_prdata = prdata_r;
   assign o_pready = pready_r;
   assign o_pslverr = pslverr_r;
   assign o_work_set = work_r;
   assign o_nv_link = link_r;
   assign o_nv_link_we = nv_we_r;
   assign o_soft_rst = soft_rst_r;
   assign o_status_led = led_r;
endmodule // cssm_top
`default_nettype wire

/* File: verilog/cssm_pkg.sv */
`default_nettype none
package cssm_pkg;
   localparam int NPAR = 8;
   localparam int PW = 16;
   localparam int NUSER = 4;

   // register byte offsets
   localparam logic [11:0] REG_CACHE_CTRL = 12'h000;
   localparam logic [11:0] REG_RESET_CTRL = 12'h004;
   localparam logic [11:0] REG_STATUS = 12'h008;
   localparam logic [11:0] REG_SET_CTRL = 12'h00C;
   // parameter words at 0x040..0x05C, user set window at 0x100..0x17C
   localparam logic [6:0] PARAM_PAGE = 7'h02;
   localparam logic [4:0] USER_PAGE = 5'h02;

   // field positions
   localparam int CACHE_MODE_BIT = 0;
   localparam int RESET_BIT = 0;
   localparam int SET_SLOT_LSB = 0;
   localparam int SET_ACT_BIT = 8;
   localparam int SET_SAVE_BIT = 9;
   localparam int STAT_PERR_BIT = 0;
   localparam int STAT_CACHE_BIT = 1;
   localparam int STAT_PEND_BIT = 2;
   localparam int STAT_BOOT_BIT = 3;
   localparam int STAT_ERR_LSB = 4;
   localparam int STAT_LINK_LSB = 8;
   localparam int STAT_VALID_LSB = 12;

   localparam logic [2:0] SLOT_FACTORY = 3'h0;
   localparam logic [2:0] MAX_USER_SLOT = 3'h4;

   // parameter indices
   localparam int IDX_VIDEO_FMT = 0;
   localparam int IDX_EXP_MODE = 1;
   localparam int IDX_EXP_TIME = 2;
   localparam int IDX_FRAME_PERIOD = 3;
   localparam int IDX_ROC_COL = 4;
   localparam int IDX_ROC_WIDTH = 5;
   localparam int IDX_TEST_IMAGE = 6;
   localparam int IDX_GAIN = 7;
   localparam logic [NPAR-1:0] CACHED_MASK = 8'h7F;

   localparam logic [PW-1:0] SENSOR_COLS = 16'h0930;
   localparam logic [PW-1:0] PAR_FACTORY [NPAR] = '{16'h0000, 16'h0000, 16'h0064, 16'h03E8,
                                                    16'h0001, 16'h0930, 16'h0000, 16'h0000};
   localparam logic [PW-1:0] PAR_MIN [NPAR] = '{16'h0000, 16'h0000, 16'h0001, 16'h000A,
                                                16'h0001, 16'h0010, 16'h0000, 16'h0000};
   localparam logic [PW-1:0] PAR_MAX [NPAR] = '{16'h0003, 16'h0003, 16'hFDE8, 16'hFDE8,
                                                16'h0930, 16'h0930, 16'h0003, 16'h00FF};
   // low bits that must be zero above the minimum (increment)
   localparam logic [PW-1:0] PAR_INC_MASK [NPAR] = '{16'h0000, 16'h0000, 16'h0000, 16'h0000,
                                                     16'h0000, 16'h000F, 16'h0000, 16'h0000};

   // timing
   localparam int CLK_MHZ = 250;
   localparam int SELFTEST_PERIOD_US = 1000;
   localparam int SELFTEST_CYC = SELFTEST_PERIOD_US * CLK_MHZ;
   localparam int BLINK_HALF_MS = 250;
   localparam int BLINK_CYC = BLINK_HALF_MS * 1000 * CLK_MHZ;
   localparam logic [3:0] BOOT_WAIT_CYC = 4'h8;
   localparam logic [3:0] BLINK_ERR_MASK = 4'hF;

   typedef enum {ST_BOOT, ST_RUN} cssm_state_t;
endpackage
`default_nettype wire

/* File: verilog/cssm_param_check.sv */
`timescale 1ns/1ps
`default_nettype none
module cssm_param_check
   import cssm_pkg::*;
(
   input wire logic [2:0] i_idx,
   input wire logic [PW-1:0] i_val,
   input wire logic [NPAR*PW-1:0] i_view,
   output logic o_ok
);
   logic [PW-1:0] mn;
   logic [PW-1:0] mx;
   logic [PW-1:0] off;
   logic [PW-1:0] col;
   logic [PW-1:0] wid;
   logic [PW-1:0] etm;
   logic [PW-1:0] per;
   logic range_ok;
   logic inc_ok;
   logic roc_ok;
   logic exp_ok;

   assign mn = PAR_MIN[i_idx];
   assign mx = PAR_MAX[i_idx];
   assign off = i_val - mn;
   assign range_ok = (i_val >= mn) && (i_val <= mx);
   assign inc_ok = (off & PAR_INC_MASK[i_idx]) == 16'h0000;
   // candidate combination with the new value substituted
   assign col = (i_idx == 3'(IDX_ROC_COL)) ? i_val : i_view[IDX_ROC_COL*PW +: PW];
   assign wid = (i_idx == 3'(IDX_ROC_WIDTH)) ? i_val : i_view[IDX_ROC_WIDTH*PW +: PW];
   assign etm = (i_idx == 3'(IDX_EXP_TIME)) ? i_val : i_view[IDX_EXP_TIME*PW +: PW];
   assign per = (i_idx == 3'(IDX_FRAME_PERIOD)) ? i_val : i_view[IDX_FRAME_PERIOD*PW +: PW];
   assign roc_ok = ({1'b0, col} + {1'b0, wid}) <= ({1'b0, SENSOR_COLS} + 17'h00001);
   assign exp_ok = etm <= per;
   assign o_ok = range_ok & inc_ok & roc_ok & exp_ok;
endmodule // cssm_param_check
`default_nettype wire

/* File: bench/cssm_top_sva.sv */
`timescale 1ns/1ps
`default_nettype none
module cssm_top_sva
   import cssm_pkg::*;
(
   input wire logic i_sys_clk,
   input wire logic i_rst,
   input wire logic i_psel,
   input wire logic i_penable,
   input wire logic i_pwrite,
   input wire logic [11:0] i_paddr,
   input wire logic [31:0] i_pwdata,
   input wire logic [31:0] o_prdata,
   input wire logic o_pready,
   input wire logic o_pslverr,
   input wire logic [2:0] o_nv_link,
   input wire logic o_nv_link_we,
   input wire logic o_soft_rst,
   input wire logic o_status_led
);
   default clocking cb @(posedge i_sys_clk); endclocking
   default disable iff (i_rst);
   wire logic acc = i_psel & i_penable;
   wire logic done = acc & o_pready;

   property p_one_wait; acc && !o_pready && !$past(i_penable) |=> o_pready; endproperty
   a_one_wait: assert property (p_one_wait) else $error("pready missing after one wait");
   property p_ready_pulse; o_pready |=> !o_pready; endproperty
   a_ready_pulse: assert property (p_ready_pulse) else $error("pready longer than one cycle");
   property p_err_ready; o_pslverr |-> done; endproperty
   a_err_ready: assert property (p_err_ready) else $error("pslverr outside completion");
   property p_unmapped; done && i_paddr == 12'h010 |-> o_pslverr; endproperty
   a_unmapped: assert property (p_unmapped) else $error("unmapped access not refused");
   property p_soft_rst; done && i_pwrite && i_paddr == REG_RESET_CTRL && i_pwdata[RESET_BIT] |-> ##[1:2] o_soft_rst;
   endproperty
   a_soft_rst: assert property (p_soft_rst) else $error("reset write gave no soft reset");
   property p_soft_pulse; o_soft_rst |=> !o_soft_rst; endproperty
   a_soft_pulse: assert property (p_soft_pulse) else $error("soft reset pulse too long");
   property p_rst_rd0; done && !i_pwrite && i_paddr == REG_RESET_CTRL |-> o_prdata == 32'h0; endproperty
   a_rst_rd0: assert property (p_rst_rd0) else $error("reset control read not zero");
   property p_we_pulse; o_nv_link_we |=> !o_nv_link_we; endproperty
   a_we_pulse: assert property (p_we_pulse) else $error("link write pulse too long");
   property p_link_range; o_nv_link <= MAX_USER_SLOT; endproperty
   a_link_range: assert property (p_link_range) else $error("link outside set range");
   property p_led; $rose(o_status_led) |=> $stable(o_status_led) [*3]; endproperty
   a_led: assert property (p_led) else $error("status led toggles too fast");

   c_soft: cover property (o_soft_rst);
   c_we: cover property (o_nv_link_we);
   c_err: cover property (o_pslverr);
endmodule // cssm_top_sva
`default_nettype wire

/* File: bench/cssm_nv_model.sv */
`timescale 1ns/1ps
`default_nettype none
module cssm_nv_model #(
   parameter int FRAME = 32
) (
   input wire logic i_clk,
   input wire logic i_rst,
   input wire logic [2:0] i_link,
   input wire logic i_link_we,
   output logic [2:0] o_link,
   output logic o_first_boot,
   output logic o_frame_done
);
   logic booted;
   int cnt;
   initial begin
      booted = 1'h0;
      cnt = 0;
      o_link = 3'h0;
      o_first_boot = 1'h1;
      o_frame_done = 1'h0;
   end
   // delivery flag drops from the second power-up on
   always @(posedge i_rst) if (booted) o_first_boot <= 1'h0;
   always @(negedge i_rst) booted <= 1'h1;
   // stored link survives power loss, free-running frames
   always @(posedge i_clk) begin
      if (i_link_we) o_link <= i_link;
      cnt <= (cnt == FRAME - 1) ? 0 : cnt + 1;
      o_frame_done <= (cnt == FRAME - 1);
   end
endmodule // cssm_nv_model
`default_nettype wire

/* File: bench/cssm_top_tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, ex, got) begin check_count++; if ((got) !== (ex)) begin n_mismatch++; \
   $display("wrong value %s expected %0h seen %0h", nm, ex, got); end end
module cssm_top_tb_top
   import cssm_pkg::*;
;
   typedef struct {logic [11:0] a; logic [15:0] d; logic [15:0] e; logic pe;} cssm_row_t;
   logic i_sys_clk, i_rst, i_psel, i_penable, i_pwrite, i_frame_done, i_nv_first_boot;
   logic [11:0] i_paddr;
   logic [31:0] i_pwdata, o_prdata, rd;
   logic [3:0] i_fault;
   logic [2:0] i_nv_link, o_nv_link;
   logic [NPAR*PW-1:0] o_work_set;
   logic o_pready, o_pslverr, o_nv_link_we, o_soft_rst, o_status_led, err;
   int check_count = 0;
   int n_mismatch = 0;
   cssm_row_t rows [11] = '{'{12'h05C, 16'h0012, 16'h0012, 1'h0}, '{12'h048, 16'h0200, 16'h0200, 1'h0},
      '{12'h048, 16'h0000, 16'h0200, 1'h1}, '{12'h044, 16'h0002, 16'h0002, 1'h0},
      '{12'h054, 16'h0935, 16'h0930, 1'h1}, '{12'h054, 16'h0105, 16'h0930, 1'h1},
      '{12'h050, 16'h0002, 16'h0001, 1'h1}, '{12'h054, 16'h0200, 16'h0200, 1'h0},
      '{12'h050, 16'h0731, 16'h0731, 1'h0}, '{12'h04C, 16'h01FF, 16'h03E8, 1'h1},
      '{12'h04C, 16'h0200, 16'h0200, 1'h0}};

   cssm_top #(.SELFTEST_CYCLES(20), .BLINK_CYCLES(8)) i_dut (.i_sys_clk, .i_rst, .i_psel, .i_penable,
      .i_pwrite, .i_paddr, .i_pwdata, .o_prdata, .o_pready, .o_pslverr, .i_frame_done, .i_fault, .i_nv_link,
      .i_nv_first_boot, .o_work_set, .o_nv_link, .o_nv_link_we, .o_soft_rst, .o_status_led);
   cssm_nv_model i_nv (.i_clk(i_sys_clk), .i_rst(i_rst), .i_link(o_nv_link), .i_link_we(o_nv_link_we),
      .o_link(i_nv_link), .o_first_boot(i_nv_first_boot), .o_frame_done(i_frame_done));

   initial begin
      i_sys_clk = 1'h0;
      forever #2 i_sys_clk = ~i_sys_clk;
   end

   function automatic logic [NPAR*PW-1:0] fac();
      for (int i = 0; i < NPAR; i++) fac[i*PW +: PW] = PAR_FACTORY[i];
   endfunction

   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      int n;
      n = 0;
      i_psel <= 1'h1;
      i_penable <= 1'h0;
      i_pwrite <= w;
      i_paddr <= a;
      i_pwdata <= d;
      @(posedge i_sys_clk);
      i_penable <= 1'h1;
      do begin
         @(posedge i_sys_clk);
         n++;
      end while (o_pready !== 1'h1 && n < 20);
      if (o_pready !== 1'h1) n_mismatch++;
      rd = o_prdata;
      err = o_pslverr;
      i_psel <= 1'h0;
      i_penable <= 1'h0;
      repeat (2) @(posedge i_sys_clk);
   endtask

   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      apb(1'h1, a, d);
   endtask

   task automatic boot_wait();
      int k;
      k = 0;
      do begin
         apb(1'h0, REG_STATUS, 32'h0);
         k++;
      end while (rd[STAT_BOOT_BIT] !== 1'h0 && k < 20);
      if (rd[STAT_BOOT_BIT] !== 1'h0) n_mismatch++;
   endtask

   task automatic conclude();
      $display("checks %0d mismatches %0d", check_count, n_mismatch);
      if (n_mismatch == 0 && check_count > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask

   initial begin
      #100000;
      n_mismatch++;
      conclude();
   end

   initial begin
      {i_psel, i_penable, i_pwrite, i_paddr, i_pwdata, i_fault} = '0;
      i_rst = 1'h1;
      repeat (2) @(posedge i_sys_clk);
      `CHK("reset work", fac(), o_work_set)
      i_rst <= 1'h0;
      @(posedge i_sys_clk);
      apb(1'h0, REG_STATUS, 32'h0);
      `CHK("booting", 1'h1, rd[STAT_BOOT_BIT])
      boot_wait();
      `CHK("first boot", fac(), o_work_set)
      $display("test boot done");
      foreach (rows[r]) begin
         wr(rows[r].a, {16'h0, rows[r].d});
         apb(1'h0, rows[r].a, 32'h0);
         `CHK("param", rows[r].e, rd[15:0])
         `CHK("work", rows[r].e, o_work_set[rows[r].a[4:2]*PW +: PW])
         apb(1'h0, REG_STATUS, 32'h0);
         `CHK("perr", rows[r].pe, rd[STAT_PERR_BIT])
      end
      $display("test table done");
      wr(REG_CACHE_CTRL, 32'h1);
      apb(1'h0, REG_STATUS, 32'h0);
      `CHK("cache on", 1'h1, rd[STAT_CACHE_BIT])
      wr(12'h048, 32'h0100);
      wr(12'h048, 32'h0180);
      wr(12'h040, 32'h0001);
      wr(12'h05C, 32'h0044);
      `CHK("held exp", 16'h0200, o_work_set[2*PW +: PW])
      `CHK("held fmt", 16'h0000, o_work_set[0 +: PW])
      `CHK("gain now", 16'h0044, o_work_set[7*PW +: PW])
      wr(REG_CACHE_CTRL, 32'h0);
      for (int k = 0; i_frame_done !== 1'h1 && k < 100; k++) @(posedge i_sys_clk);
      if (i_frame_done !== 1'h1) n_mismatch++;
      repeat (2) @(posedge i_sys_clk);
      `CHK("commit exp", 16'h0180, o_work_set[2*PW +: PW])
      `CHK("commit fmt", 16'h0001, o_work_set[0 +: PW])
      $display("test cache done");
      wr(REG_SET_CTRL, 32'h201);
      wr(REG_SET_CTRL, 32'h205);
      apb(1'h0, REG_STATUS, 32'h0);
      `CHK("valid", 4'h1, rd[STAT_VALID_LSB +: 4])
      wr(12'h05C, 32'h0077);
      wr(REG_SET_CTRL, 32'h101);
      `CHK("activate", {16'h0044, 16'h0, 16'h0200, 16'h0731, 16'h0200, 16'h0180, 16'h0002, 16'h0001},
           o_work_set)
      `CHK("link", 3'h1, i_nv_link)
      wr(12'h05C, 32'h0099);
      wr(REG_RESET_CTRL, 32'h1);
      boot_wait();
      `CHK("soft boot", {16'h0044, 16'h0, 16'h0200, 16'h0731, 16'h0200, 16'h0180, 16'h0002, 16'h0001},
           o_work_set)
      i_rst <= 1'h1;
      repeat (8) @(posedge i_sys_clk);
      i_rst <= 1'h0;
      @(posedge i_sys_clk);
      boot_wait();
      `CHK("fallback", fac(), o_work_set)
      wr(REG_SET_CTRL, 32'h100);
      `CHK("factory link", 3'h0, o_nv_link)
      wr(12'h13C, 32'h00000055);
      apb(1'h0, 12'h13C, 32'h0);
      `CHK("upload", 32'h00000055, rd)
      apb(1'h0, 12'h160, 32'h0);
      `CHK("empty slot", 32'h00000000, rd)
      $display("test sets done");
      apb(1'h0, 12'h010, 32'h0);
      `CHK("unmapped err", 1'h1, err)
      `CHK("unmapped rd", 32'h0, rd)
      apb(1'h0, REG_RESET_CTRL, 32'h0);
      `CHK("reset rd", 32'h0, rd)
      `CHK("led steady", 1'h1, o_status_led)
      i_fault <= 4'h5;
      repeat (80) @(posedge i_sys_clk);
      apb(1'h0, REG_STATUS, 32'h0);
      `CHK("fault code", 4'h5, rd[STAT_ERR_LSB +: 4])
      err = o_status_led;
      repeat (8) @(posedge i_sys_clk);
      `CHK("led blink", ~err, o_status_led)
      repeat (40) @(posedge i_sys_clk);
      $display("test status done");
      conclude();
   end
endmodule // cssm_top_tb_top
bind cssm_top cssm_top_sva i_sva (.i_sys_clk, .i_rst, .i_psel, .i_penable, .i_pwrite, .i_paddr, .i_pwdata,
   .o_prdata, .o_pready, .o_pslverr, .o_nv_link, .o_nv_link_we, .o_soft_rst, .o_status_led);
`default_nettype wire
